// ==== verilog/uart_pkg.sv ====
// Shared constants, types and helpers for the transmitter with auto-baud
// ---------------------------------------------------------------------
package uart_pkg;

   // --------------------------------------------------------------------
   // Register indexes
   // --------------------------------------------------------------------
   localparam logic [3:0] A_TXSTA   = 4'h0;
   localparam logic [3:0] A_RCSTA   = 4'h1;
   localparam logic [3:0] A_BAUDCON = 4'h2;
   localparam logic [3:0] A_BRGL    = 4'h3;
   localparam logic [3:0] A_BAUD_HIGH_SPEED_SELECT    = 4'h4;
   localparam logic [3:0] A_TXBUF   = 4'h5;
   localparam logic [3:0] A_RCREG   = 4'h6;
   localparam logic [3:0] A_PERIPHERAL_INTERRUPT_FLAGS_1    = 4'h7;
   localparam logic [3:0] A_PERIPHERAL_INTERRUPT_ENABLES_1    = 4'h8;

   // --------------------------------------------------------------------
   // Field positions
   // --------------------------------------------------------------------
   localparam int B_TX9    = 6;
   localparam int B_TRANSMIT_ENABLE   = 5;
   localparam int B_SYNC   = 4;
   localparam int B_BAUD_HIGH_SPEED_SELECT   = 2;
   localparam int B_NINTH_TRANSMIT_BIT   = 0;
   localparam int B_SERIAL_PORT_ENABLE   = 7;
   localparam int B_AUTOBAUD_OVERFLOW = 7;
   localparam int B_BAUD_16BIT_SELECT  = 3;
   localparam int B_WUE    = 1;
   localparam int B_AUTOBAUD_ENABLE  = 0;

   // --------------------------------------------------------------------
   // Timing
   // --------------------------------------------------------------------
   localparam int         INSTR_CLKS = 4;
   localparam logic [1:0] LOAD_LAST  = 2'(INSTR_CLKS - 1);
   localparam int         ABD_EDGES  = 5;
   localparam logic [2:0] EDGE_LAST  = 3'(ABD_EDGES - 1);
   localparam logic [3:0] LAST_BIT8  = 4'h7;
   localparam logic [3:0] LAST_BIT9  = 4'h8;
   localparam logic [9:0] PRE_SLOW   = 10'h040;
   localparam logic [9:0] PRE_MID    = 10'h010;
   localparam logic [9:0] PRE_FAST   = 10'h004;
   localparam int         ABD_SHIFT  = 3;

   typedef logic [9:0] presc_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bus_req_t;

   function automatic logic wr_hit(input bus_req_t r, input logic [3:0] a);
      return r.wr && (r.addr == a);
   endfunction : wr_hit

   function automatic logic rd_hit(input bus_req_t r, input logic [3:0] a);
      return r.rd && (r.addr == a);
   endfunction : rd_hit

   // Prescale in clocks per baud counter step
   function automatic presc_t presc(input logic b16, input logic bh,
                                    input logic abd);
      presc_t p;
      p = (b16 && bh) ? PRE_FAST : ((b16 || bh) ? PRE_MID : PRE_SLOW);
      return abd ? presc_t'(p << ABD_SHIFT) : p;
   endfunction : presc

endpackage : uart_pkg

// ==== verilog/baud_ticker.sv ====
// Prescaler that issues one-cycle steps for the baud counter
`timescale 1ns/1ps
module baud_ticker (
   input  wire logic            clk,
   input  wire logic            rst_n,
   input  wire logic            restart,
   input  wire uart_pkg::presc_t period,
   output logic                 tick
);
   import uart_pkg::*;

   presc_t cnt_reg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_reg <= '0;
         tick    <= 1'h0;
      end
      else if (restart)
      begin
         cnt_reg <= '0;
         tick    <= 1'h0;
      end
      // Greater-or-equal so a shrunk period never strands the count
      else if (cnt_reg >= period - presc_t'(1))
      begin
         cnt_reg <= '0;
         tick    <= 1'h1;
      end
      else
      begin
         cnt_reg <= cnt_reg + presc_t'(1);
         tick    <= 1'h0;
      end
   end

endmodule : baud_ticker

// ==== verilog/uart_tx_autobaud.sv ====
// Asynchronous transmitter with auto-baud measurement and register port
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module uart_tx_autobaud (
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire uart_pkg::bus_req_t req,
   output logic [7:0]              rdata,
   input  wire logic               receive_pin,
   output logic                    tx_pin
);
   import uart_pkg::*;

   typedef enum logic [2:0] {AB_OFF, AB_BRK_FALL, AB_BRK_RISE,
                             AB_WAIT_START, AB_WAIT_RISE, AB_COUNT} ab_t;
   typedef enum logic [2:0] {TX_IDLE, TX_LOAD, TX_START, TX_DATA,
                             TX_STOP} tx_t;

   logic       sync_reg, serial_port_enable_reg, tx9_reg, transmit_enable_reg, baud_high_speed_select_reg;
   logic       ninth_transmit_bit_reg, baud_16bit_select_reg;
   logic [7:0] peripheral_interrupt_enables_1_reg;
   logic       rx_s1, rx_s2, rx_s3, rx_lvl_reg;
   ab_t        ab_state;
   logic       autobaud_enable_reg, wue_reg;
   logic [2:0] edge_reg;
   logic [7:0] brg_lo_reg, brg_hi_reg;
   logic [15:0] brg_cnt_reg;
   logic       bit_tick;
   logic       txif_reg, rcif_reg, autobaud_overflow_reg;
   tx_t        tx_state;
   logic [8:0] buf_reg, tsr_reg;
   logic       full_reg;
   logic [3:0] bits_reg;
   logic [1:0] load_reg;
   logic       presc_tick;

   // --------------------------------------------------------------------
   // Decoded events
   // --------------------------------------------------------------------
   logic rx_rise, rx_fall, abd_start, abd_abort, abd_done, abd_wrap;
   logic counting, transmit_enable_rise, txbuf_wr, tx_active, load_done, shift_register_empty;
   logic restart;
   logic [15:0] brg_val, divisor;

   assign brg_val   = {brg_hi_reg, brg_lo_reg};
   assign divisor   = {brg_hi_reg & {8{baud_16bit_select_reg}}, brg_lo_reg};
   assign rx_rise   = (rx_s2 == rx_s3) && rx_s2 && !rx_lvl_reg;
   assign rx_fall   = (rx_s2 == rx_s3) && !rx_s2 && rx_lvl_reg;
   assign counting  = (ab_state == AB_COUNT);
   assign abd_start = wr_hit(req, A_BAUDCON) && req.wdata[B_AUTOBAUD_ENABLE]
                      && !autobaud_enable_reg && !sync_reg;
   assign abd_abort = wr_hit(req, A_BAUDCON) && !req.wdata[B_AUTOBAUD_ENABLE]
                      && autobaud_enable_reg;
   assign abd_done  = counting && rx_rise && (edge_reg == EDGE_LAST);
   assign abd_wrap  = counting && presc_tick && (brg_val == '1);
   assign transmit_enable_rise = wr_hit(req, A_TXSTA) && req.wdata[B_TRANSMIT_ENABLE]
                      && !transmit_enable_reg;
   assign txbuf_wr  = wr_hit(req, A_TXBUF) && !autobaud_enable_reg;
   assign tx_active = serial_port_enable_reg && transmit_enable_reg && !sync_reg;
   assign load_done = (tx_state == TX_LOAD) && (load_reg == LOAD_LAST);
   assign shift_register_empty      = (tx_state == TX_IDLE) || (tx_state == TX_LOAD);
   assign restart   = abd_start || load_done
                      || (ab_state == AB_WAIT_RISE && rx_rise);

   // --------------------------------------------------------------------
   // Step generator
   // --------------------------------------------------------------------
   // rate select
   baud_ticker u_ticker (
      .clk     (clk),
      .rst_n   (rst_n),
      .restart (restart),
      .period  (presc(baud_16bit_select_reg, baud_high_speed_select_reg, autobaud_enable_reg)),
      .tick    (presc_tick)
   );

   // --------------------------------------------------------------------
   // Configuration bits
   // --------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_reg  <= 1'h0;
         serial_port_enable_reg  <= 1'h0;
         tx9_reg   <= 1'h0;
         transmit_enable_reg  <= 1'h0;
         baud_high_speed_select_reg  <= 1'h0;
         ninth_transmit_bit_reg  <= 1'h0;
         baud_16bit_select_reg <= 1'h0;
         peripheral_interrupt_enables_1_reg  <= '0;
      end
      else
      begin
         if (wr_hit(req, A_TXSTA))
         begin
            tx9_reg  <= req.wdata[B_TX9];
            transmit_enable_reg <= req.wdata[B_TRANSMIT_ENABLE];
            sync_reg <= req.wdata[B_SYNC];
            baud_high_speed_select_reg <= req.wdata[B_BAUD_HIGH_SPEED_SELECT];
            ninth_transmit_bit_reg <= req.wdata[B_NINTH_TRANSMIT_BIT];
         end
         if (wr_hit(req, A_RCSTA))
            serial_port_enable_reg <= req.wdata[B_SERIAL_PORT_ENABLE];
         if (wr_hit(req, A_BAUDCON))
            baud_16bit_select_reg <= req.wdata[B_BAUD_16BIT_SELECT];
         if (wr_hit(req, A_PERIPHERAL_INTERRUPT_ENABLES_1))
            peripheral_interrupt_enables_1_reg <= req.wdata;
      end
   end

   // --------------------------------------------------------------------
   // Receive pin synchroniser
   // --------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_s1      <= 1'h1;
         rx_s2      <= 1'h1;
         rx_s3      <= 1'h1;
         rx_lvl_reg <= 1'h1;
      end
      else
      begin
         rx_s1 <= receive_pin;
         rx_s2 <= rx_s1;
         rx_s3 <= rx_s2;
         if (rx_s2 == rx_s3)
            rx_lvl_reg <= rx_s2;
      end
   end

   // --------------------------------------------------------------------
   // Auto-baud sequencer
   // --------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ab_state  <= AB_OFF;
         autobaud_enable_reg <= 1'h0;
         wue_reg   <= 1'h0;
         edge_reg  <= '0;
      end
      else
      begin
         if (wr_hit(req, A_BAUDCON))
            wue_reg <= req.wdata[B_WUE];
         if (abd_abort)
         begin
            ab_state  <= AB_OFF;
            autobaud_enable_reg <= 1'h0;
         end
         else
         begin
            unique case (ab_state)
               AB_OFF:
                  if (abd_start)
                  begin
                     autobaud_enable_reg <= 1'h1;
                     ab_state  <= req.wdata[B_WUE] ? AB_BRK_FALL
                                                   : AB_WAIT_START;
                  end
               AB_BRK_FALL:
                  if (rx_fall)
                     ab_state <= AB_BRK_RISE;
               AB_BRK_RISE:
                  if (rx_rise)
                  begin
                     wue_reg  <= 1'h0;
                     ab_state <= AB_WAIT_START;
                  end
               AB_WAIT_START:
                  if (rx_fall)
                     ab_state <= AB_WAIT_RISE;
               AB_WAIT_RISE:
                  if (rx_rise)
                  begin
                     edge_reg <= 3'h1;
                     ab_state <= AB_COUNT;
                  end
               AB_COUNT:
                  if (rx_rise)
                  begin
                     if (edge_reg == EDGE_LAST)
                     begin
                        autobaud_enable_reg <= 1'h0;
                        ab_state  <= AB_OFF;
                     end
                     else
                        edge_reg <= edge_reg + 3'h1;
                  end
            endcase
         end
      end
   end

   // --------------------------------------------------------------------
   // Baud counter and divisor bytes
   // --------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         brg_lo_reg  <= '0;
         brg_hi_reg  <= '0;
         brg_cnt_reg <= '0;
         bit_tick    <= 1'h0;
      end
      else
      begin
         bit_tick <= 1'h0;
         if (abd_start)
            {brg_hi_reg, brg_lo_reg} <= '0;
         else if (counting && presc_tick)
            {brg_hi_reg, brg_lo_reg} <= brg_val + 16'h0001;
         else if (!autobaud_enable_reg)
         begin
            if (wr_hit(req, A_BRGL))
               brg_lo_reg <= req.wdata;
            if (wr_hit(req, A_BAUD_HIGH_SPEED_SELECT))
               brg_hi_reg <= req.wdata;
         end
         if (load_done)
            brg_cnt_reg <= divisor;
         else if (presc_tick && !autobaud_enable_reg)
         begin
            if (brg_cnt_reg == '0)
            begin
               brg_cnt_reg <= divisor;
               bit_tick    <= 1'h1;
            end
            else
               brg_cnt_reg <= brg_cnt_reg - 16'h0001;
         end
      end
   end

   // --------------------------------------------------------------------
   // Status flags, set wins over clear
   // --------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         txif_reg   <= 1'h0;
         rcif_reg   <= 1'h0;
         autobaud_overflow_reg <= 1'h0;
      end
      else
      begin
         if (abd_wrap)
            autobaud_overflow_reg <= 1'h1;
         else if (wr_hit(req, A_BAUDCON))
            autobaud_overflow_reg <= req.wdata[B_AUTOBAUD_OVERFLOW];
         if (abd_done)
            rcif_reg <= 1'h1;
         else if (rd_hit(req, A_RCREG))
            rcif_reg <= 1'h0;
         if (load_done || transmit_enable_rise)
            txif_reg <= 1'h1;
         else if (txbuf_wr)
            txif_reg <= 1'h0;
      end
   end

   // --------------------------------------------------------------------
   // Transmitter
   // --------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_state <= TX_IDLE;
         buf_reg  <= '0;
         full_reg <= 1'h0;
         tsr_reg  <= '0;
         bits_reg <= '0;
         load_reg <= '0;
         tx_pin   <= 1'h1;
      end
      else
      begin
         if (txbuf_wr)
         begin
            buf_reg  <= {ninth_transmit_bit_reg, req.wdata};
            full_reg <= 1'h1;
         end
         else if (load_done)
            full_reg <= 1'h0;
         if (!tx_active)
         begin
            tx_state <= TX_IDLE;
            tx_pin   <= 1'h1;
         end
         else
         begin
            unique case (tx_state)
               TX_IDLE:
                  if (full_reg)
                  begin
                     load_reg <= '0;
                     tx_state <= TX_LOAD;
                  end
               TX_LOAD:
                  if (load_done)
                  begin
                     tsr_reg  <= buf_reg;
                     bits_reg <= '0;
                     tx_pin   <= 1'h0;
                     tx_state <= TX_START;
                  end
                  else
                     load_reg <= load_reg + 2'h1;
               TX_START:
                  if (bit_tick)
                  begin
                     tx_pin   <= tsr_reg[0];
                     tsr_reg  <= tsr_reg >> 1;
                     tx_state <= TX_DATA;
                  end
               TX_DATA:
                  if (bit_tick)
                  begin
                     if (bits_reg == (tx9_reg ? LAST_BIT9 : LAST_BIT8))
                     begin
                        tx_pin   <= 1'h1;
                        tx_state <= TX_STOP;
                     end
                     else
                     begin
                        tx_pin   <= tsr_reg[0];
                        tsr_reg  <= tsr_reg >> 1;
                        bits_reg <= bits_reg + 4'h1;
                     end
                  end
               TX_STOP:
                  if (bit_tick)
                  begin
                     load_reg <= '0;
                     tx_state <= full_reg ? TX_LOAD : TX_IDLE;
                  end
            endcase
         end
      end
   end

   // --------------------------------------------------------------------
   // Register read port
   // --------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata <= '0;
      else if (!req.rd)
         rdata <= '0;
      else
      begin
         case (req.addr)
            A_TXSTA:   rdata <= {1'h0, tx9_reg, transmit_enable_reg, sync_reg, 1'h0,
                                 baud_high_speed_select_reg, shift_register_empty, ninth_transmit_bit_reg};
            A_RCSTA:   rdata <= {serial_port_enable_reg, 7'h00};
            // Receiver idle bit reads low while measuring
            A_BAUDCON: rdata <= {autobaud_overflow_reg, !autobaud_enable_reg, 2'h0, baud_16bit_select_reg,
                                 1'h0, wue_reg, autobaud_enable_reg};
            A_BRGL:    rdata <= brg_lo_reg;
            A_BAUD_HIGH_SPEED_SELECT:    rdata <= brg_hi_reg;
            A_TXBUF:   rdata <= buf_reg[7:0];
            A_PERIPHERAL_INTERRUPT_FLAGS_1:    rdata <= {2'h0, rcif_reg, txif_reg, 4'h0};
            A_PERIPHERAL_INTERRUPT_ENABLES_1:    rdata <= peripheral_interrupt_enables_1_reg;
            // Receive data is meaningless here; unmapped also reads zero
            default:   rdata <= '0;
         endcase
      end
   end

   // --------------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_abd_clear;
      abd_start |=> (brg_val == '0) && autobaud_enable_reg;
   endproperty
   a_abd_clear: assert property (p_abd_clear)
      else $error("counter not cleared at auto-baud start");

   property p_abd_async;
      counting |-> !sync_reg && (ab_state != AB_OFF);
   endproperty
   a_abd_async: assert property (p_abd_async)
      else $error("measurement outside asynchronous mode");

   property p_fifth_edge;
      abd_done |=> !autobaud_enable_reg && rcif_reg && (ab_state == AB_OFF);
   endproperty
   a_fifth_edge: assert property (p_fifth_edge)
      else $error("fifth edge did not end auto-baud");

   property p_wrap;
      abd_wrap && !abd_abort && !abd_done
      |=> autobaud_overflow_reg && autobaud_enable_reg && brg_val == '0;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("counter wrap mishandled");

   property p_txif_sw;
      $fell(txif_reg) |-> $past(txbuf_wr);
   endproperty
   a_txif_sw: assert property (p_txif_sw)
      else $error("transmit flag cleared without buffer write");

   property p_load;
      (tx_state == TX_IDLE) && tx_active && full_reg && !txbuf_wr
      ##1 tx_active [*4] |=> txif_reg && !tx_pin;
   endproperty
   a_load: assert property (p_load)
      else $error("buffer transfer not one instruction cycle");

   property p_transmit_enable;
      transmit_enable_rise |=> txif_reg;
   endproperty
   a_transmit_enable: assert property (p_transmit_enable)
      else $error("transmit enable did not set flag");

   property p_lsb;
      (tx_state == TX_START) && bit_tick && tx_active
      |=> tx_pin == $past(tsr_reg[0]);
   endproperty
   a_lsb: assert property (p_lsb)
      else $error("first data bit not least significant");

   property p_locked;
      wr_hit(req, A_TXBUF) && autobaud_enable_reg && !full_reg |=> !full_reg;
   endproperty
   a_locked: assert property (p_locked)
      else $error("buffer written during auto-baud");

   property p_stop;
      (tx_state == TX_STOP) |-> tx_pin;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop bit not high");

   c_abd_done: cover property (abd_done);
   c_wrap:     cover property (abd_wrap);
   c_frame:    cover property ((tx_state == TX_STOP) && bit_tick);
   c_b2b:      cover property ((tx_state == TX_STOP) && bit_tick
                               && full_reg);

endmodule : uart_tx_autobaud

// ==== tb/uart_line_partner.sv ====
// Remote serial partner: sends characters, captures the transmit line
`timescale 1ns/1ps
module uart_line_partner (
   input  wire logic clk,
   input  wire logic tx_pin,
   output logic      line
);
   initial line = 1'b1;

   task automatic send(input logic [7:0] b, input int n);
      line <= 1'b0;
      repeat (n) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
         line <= b[i];
         repeat (n) @(posedge clk);
      end
      line <= 1'b1;
      repeat (n) @(posedge clk);
   endtask : send

   // Mid-bit sampling; stop bit lands above the data
   task automatic recv(input int n, input int nb, output logic [9:0] d);
      int w;
      w = 0;
      d = '0;
      while (tx_pin !== 1'b0 && w < 4000)
      begin
         @(posedge clk);
         w++;
      end
      repeat (n / 2) @(posedge clk);
      for (int i = 0; i <= nb; i++)
      begin
         repeat (n) @(posedge clk);
         d[i] = tx_pin;
      end
   endtask : recv
endmodule : uart_line_partner

// ==== tb/uart_tx_autobaud_bench.sv ====
// Self-checking bench for the transmitter with auto-baud
`timescale 1ns/1ps
module uart_tx_autobaud_bench;
   import uart_pkg::*;
   logic       clk;
   logic       rst_n;
   logic       receive_pin;
   logic       tx_pin;
   bus_req_t   req;
   logic [7:0] rdata;
   logic [7:0] v;
   logic [7:0] lo;
   logic [9:0] frm;
   int         error_cnt = 0;
   int         n_tests = 0;
   int         cyc = 0;

   uart_tx_autobaud dut_u (.clk(clk), .rst_n(rst_n), .req(req),
      .rdata(rdata), .receive_pin(receive_pin), .tx_pin(tx_pin));
   uart_line_partner part_u (.clk(clk), .tx_pin(tx_pin),
      .line(receive_pin));

   // ------------------------------------------------------------
   // Bus and checking tasks
   // ------------------------------------------------------------
   task automatic check(input string nm, input logic [15:0] seen, exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
      @(posedge clk);
   endtask : wr

   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1 d = rdata;
      @(posedge clk);
   endtask : rd

   task automatic rc(input string nm, input logic [3:0] a,
                     input logic [7:0] e);
      rd(a, v);
      check(nm, 16'(v), 16'(e));
   endtask : rc

   task automatic summarize;
      if (error_cnt == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Hang guard, well above the few thousand cycles needed
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 12000)
      begin
         error_cnt++;
         summarize();
      end
   end

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial
   begin
      req = '0;
      rst_n = 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rc("txsta_rst", A_TXSTA, 8'h02);
      rc("baudcon_rst", A_BAUDCON, 8'h40);
      rc("unmapped", 4'h9, 8'h00);
      rc("flags_rst", A_PERIPHERAL_INTERRUPT_FLAGS_1, 8'h00);
      wr(A_TXSTA, 8'h10);
      wr(A_BAUDCON, 8'h01);
      rc("abd_in_sync", A_BAUDCON, 8'h40);
      wr(A_TXSTA, 8'h00);
      wr(A_BAUDCON, 8'h80);
      rc("ovf_sw_set", A_BAUDCON, 8'hc0);
      wr(A_BAUDCON, 8'h08);
      wr(A_RCSTA, 8'h80);
      wr(A_BRGL, 8'h03);
      wr(A_TXSTA, 8'h24);
      rc("transmit_enable_flag", A_PERIPHERAL_INTERRUPT_FLAGS_1, 8'h10);
      // Bit time is (3+1)*4 clocks with both selects set
      fork
         part_u.recv(16, 8, frm);
         begin
            wr(A_TXBUF, 8'ha5);
            rc("flag_clr", A_PERIPHERAL_INTERRUPT_FLAGS_1, 8'h00);
         end
      join
      check("frame8", 16'(frm), 16'h01a5);
      wr(A_TXSTA, 8'h65);
      fork
         part_u.recv(16, 9, frm);
         begin
            wr(A_TXBUF, 8'h3c);
            repeat (8) @(posedge clk);
            wr(A_TXBUF, 8'hc3);
         end
      join
      check("frame9_a", 16'(frm), 16'h033c);
      part_u.recv(16, 9, frm);
      check("frame9_b", 16'(frm), 16'h03c3);
      repeat (24) @(posedge clk);
      rc("tsr_empty", A_TXSTA, 8'h67);
      rc("flag_set", A_PERIPHERAL_INTERRUPT_FLAGS_1, 8'h10);
      wr(A_BAUDCON, 8'h09);
      wr(A_TXBUF, 8'hff);
      part_u.send(8'h55, 322);
      repeat (8) @(posedge clk);
      rc("abd_done", A_BAUDCON, 8'h48);
      rd(A_BRGL, lo);
      rd(A_BAUD_HIGH_SPEED_SELECT, v);
      // Eight bit times of 322 clocks at one step per 32 clocks
      check("abd_count", 16'({v, lo} == 16'h0050 || {v, lo} == 16'h0051),
            16'h0001);
      rc("rx_flag", A_PERIPHERAL_INTERRUPT_FLAGS_1, 8'h30);
      rd(A_RCREG, v);
      rc("rx_flag_clr", A_PERIPHERAL_INTERRUPT_FLAGS_1, 8'h10);
      rc("buf_kept", A_TXBUF, 8'hc3);
      summarize();
   end
endmodule : uart_tx_autobaud_bench
